// ==== core/iop_pkg.sv ====
// shared constants, register map and carrier types for the ionizer control
// assumes a single 125 MHz controller clock and a synchronous reset
package iop_pkg;

  // clock and time base
  localparam int unsigned CLK_HZ       = 125_000_000;
  localparam int unsigned DEB_MS       = 10;
  localparam int unsigned DEB_CYC      = CLK_HZ / 1000 * DEB_MS;
  localparam int unsigned SEC_CYC      = CLK_HZ;

  // times in their own units
  localparam int unsigned HOT_RESUME_MIN = 30;
  localparam int unsigned RETRY_MIN      = 30;
  localparam int unsigned OK_CLEAR_MIN   = 10;
  localparam int unsigned CHECK_HOLD_S   = 15;
  localparam int unsigned HOT_RESUME_S   = HOT_RESUME_MIN * 60;
  localparam int unsigned RETRY_S        = RETRY_MIN * 60;
  localparam int unsigned OK_CLEAR_S     = OK_CLEAR_MIN * 60;

  // limits
  localparam logic [7:0] TEMP_HOT_C    = 8'h28;
  localparam logic [4:0] DIS_LIMIT     = 5'h18;

  // wishbone register map (byte addresses)
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;

  // control register fields
  localparam int unsigned CTRL_PAT_EN  = 0;
  localparam int unsigned CTRL_UL_LSB  = 8;
  localparam int unsigned CTRL_CL_LSB  = 16;
  localparam logic [31:0] CTRL_RESET   = 32'h003c_3c01;

  // status register fields
  localparam int unsigned ST_MODE_LSB  = 0;
  localparam int unsigned ST_CHECK     = 2;
  localparam int unsigned ST_HV        = 3;
  localparam int unsigned ST_DIS_ERR   = 4;
  localparam int unsigned ST_BRK_ERR   = 5;
  localparam int unsigned ST_CONN_OPEN = 6;
  localparam int unsigned ST_HOT       = 7;
  localparam int unsigned ST_CNT_LSB   = 8;

  typedef enum logic [1:0] {
    IOP_OFF  = 2'b00,
    IOP_SOLO = 2'b01,
    IOP_COMB = 2'b11
  } iop_state_t;

  // synchronous one-cycle events, except ion_btn which is a raw level
  typedef struct packed {
    logic ion_btn;
    logic pwr_stop;
    logic aqm_btn;
    logic man_pwr;
    logic off_tmr;
    logic on_tmr;
  } iop_evt_t;

  typedef struct packed {
    logic       ion_on;
    logic       solo_limits;
    logic       hv_en;
    logic       ion_led;
    logic       ion_blink;
    logic       tmr_blink;
    logic       fan_step_cool_low;
    logic       check;
    logic       beep_short;
    logic       beep_long;
    logic       resume_prev;
    iop_state_t saved_mode;
  } iop_out_t;

endpackage : iop_pkg

// ==== core/iop_sync_deb.sv ====
// two-flop synchroniser followed by a stable-time debounce
// assumes the raw input may change at any time relative to clk_i
`timescale 1ns/100ps
module iop_sync_deb #(
  parameter int unsigned DEB_CYC = 1_250_000,
  parameter logic        INIT    = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic raw_i,
  output logic      level_o
);
  import iop_pkg::*;

  logic        meta_ff;
  logic        sync_ff;
  logic [31:0] cnt_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_ff <= INIT;
      sync_ff <= INIT;
    end else begin
      meta_ff <= raw_i;
      sync_ff <= meta_ff;
    end
  end

  // level moves only after it has held a full debounce window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= 32'h0000_0000;
      level_o <= INIT;
    end else if (sync_ff == level_o) begin
      cnt_ff <= 32'h0000_0000;
    end else if (cnt_ff == DEB_CYC - 1) begin
      cnt_ff  <= 32'h0000_0000;
      level_o <= sync_ff;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  a_deb_no_glitch: assert property (@(posedge clk_i) disable iff (rst_i)
    (level_o != $past(level_o)) |-> (cnt_ff == 32'h0000_0000)
      && ($past(sync_ff) == level_o))
    else $error("debounced level moved without a stable window");

endmodule : iop_sync_deb

// ==== core/iop_ctrl.sv ====
// negative-ion purifier control: mode, pause, error detection, wishbone regs
// assumes event inputs other than ion_btn are synchronous one-cycle pulses; the mode restore
// value comes from non-volatile storage and is valid when reset releases
//
// Our own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
// How it works
// - button starts combined or stand-alone operation
// - power stop, rebutton, monitor, off timer end
// - stopped fan pauses output until it runs; check mode keeps output on regardless
// - hot intake pauses, thirty cool minutes resume; check mode keeps output on regardless
// - stand-alone: auto fan only, no powerful
// - auto fan alternates upper low, cool low
// - stand-alone: auto swing only, requests ignored
// - on timer resumes without ionizer; off stops
// - indicator lights whenever ionizer operation begins
// - short beeps, long beep stand-alone to stop
// - power return restores previous ionizer operation
// - user switch-off forgets ionizer state
// - fifteen second hold enters check mode
// - open connector blinks indicator during operation
// - low feedback records discharge, removes power
// - retry supply every thirty minutes
// - blink after 24 discharges, check immediate
// - counter clears after ten good minutes
// - stop, manual, timer, stand-alone button stop, reset clear error
// - high feedback while stopped flags breakdown
// - low feedback in operation clears breakdown
module iop_ctrl #(
  parameter int unsigned SEC_CYC = iop_pkg::SEC_CYC,
  parameter int unsigned DEB_CYC = iop_pkg::DEB_CYC
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire iop_pkg::iop_evt_t evt_i,
  input  wire logic              unit_run_i,
  input  wire logic              aqm_active_i,
  input  wire logic              fan_run_i,
  input  wire logic [7:0]        intake_temp_i,
  input  wire logic              fb_raw_i,
  input  wire logic              conn_raw_i,
  input  wire iop_pkg::iop_state_t saved_mode_i,
  output iop_pkg::iop_out_t      out_o
);
  import iop_pkg::*;

  iop_state_t  state_ff;
  iop_state_t  nxt_state;
  logic        check_ff;
  logic        nxt_check;
  logic        restored_ff;
  logic        btn_db;
  logic        fb_db;
  logic        conn_db;
  logic        btn_prev_ff;
  logic        release_w;
  logic [4:0]  hold_sec_ff;
  logic [26:0] tick_cnt_ff;
  logic        tick_ff;
  logic        hot_ff;
  logic [10:0] cool_sec_ff;
  logic        hv_en_ff;
  logic        nxt_hv_en;
  logic        settled_ff;
  logic        armed_ff;
  logic        off_arm_ff;
  logic        off_ok_ff;
  logic        dis_evt;
  logic        dis_wait_ff;
  logic [10:0] retry_sec_ff;
  logic [4:0]  dis_cnt_ff;
  logic [9:0]  ok_sec_ff;
  logic        dis_err_ff;
  logic        brk_err_ff;
  logic        err_clr;
  logic        beep_s;
  logic        beep_l;
  logic        resume_prev;
  logic [31:0] ctrl_ff;
  logic [7:0]  pat_sec_ff;
  logic        pat_cool_ff;
  logic [7:0]  pat_lim;
  logic        ion_on;
  logic        wb_req;

  // button, feedback and connector are asynchronous to the controller
  iop_sync_deb #(.DEB_CYC(DEB_CYC), .INIT(1'b0)) u_btn (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (evt_i.ion_btn),
    .level_o(btn_db)
  );
  iop_sync_deb #(.DEB_CYC(DEB_CYC), .INIT(1'b0)) u_fb (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (fb_raw_i),
    .level_o(fb_db)
  );
  iop_sync_deb #(.DEB_CYC(DEB_CYC), .INIT(1'b1)) u_conn (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .raw_i  (conn_raw_i),
    .level_o(conn_db)
  );

  assign ion_on    = (state_ff != IOP_OFF);
  assign release_w = btn_prev_ff & ~btn_db;

  // single second tick shared by every long timer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= 27'h000_0000;
      tick_ff     <= 1'b0;
    end else if (tick_cnt_ff == 27'(SEC_CYC - 1)) begin
      tick_cnt_ff <= 27'h000_0000;
      tick_ff     <= 1'b1;
    end else begin
      tick_cnt_ff <= tick_cnt_ff + 27'h000_0001;
      tick_ff     <= 1'b0;
    end
  end

  // held time measured in seconds, saturating at the check threshold
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      btn_prev_ff <= 1'b0;
      hold_sec_ff <= 5'h00;
    end else begin
      btn_prev_ff <= btn_db;
      if (!btn_db) begin
        hold_sec_ff <= 5'h00;
      end else if (tick_ff && hold_sec_ff < 5'(CHECK_HOLD_S)) begin
        hold_sec_ff <= hold_sec_ff + 5'h01;
      end
    end
  end

  // mode decisions; acting on release lets a long hold mean check mode
  always_comb begin
    nxt_state   = state_ff;
    nxt_check   = check_ff;
    beep_s      = 1'b0;
    beep_l      = 1'b0;
    err_clr     = 1'b0;
    resume_prev = 1'b0;
    if (!restored_ff) begin
      unique case (saved_mode_i)
        IOP_SOLO: nxt_state = IOP_SOLO;
        IOP_COMB: nxt_state = IOP_COMB;
        default:  nxt_state = IOP_OFF;
      endcase
    end else if (evt_i.off_tmr || evt_i.pwr_stop || evt_i.man_pwr) begin
      nxt_state = IOP_OFF;
      err_clr   = 1'b1;
      beep_l    = (state_ff == IOP_SOLO);
    end else if (evt_i.aqm_btn) begin
      nxt_state = IOP_OFF;
    end else if (release_w) begin
      if (ion_on && hold_sec_ff >= 5'(CHECK_HOLD_S)) begin
        nxt_check = 1'b1;
      end else begin
        unique case (state_ff)
          IOP_OFF: begin
            nxt_state = unit_run_i ? IOP_COMB : IOP_SOLO;
            beep_s    = 1'b1;
          end
          IOP_SOLO: begin
            nxt_state = IOP_OFF;
            beep_l    = 1'b1;
            err_clr   = 1'b1;
          end
          IOP_COMB: begin
            nxt_state = IOP_OFF;
            beep_s    = 1'b1;
          end
          default: nxt_state = IOP_OFF;
        endcase
      end
    end else if (state_ff == IOP_COMB && !unit_run_i) begin
      nxt_state = IOP_OFF;
    end else if (evt_i.on_tmr && !ion_on && !unit_run_i) begin
      resume_prev = 1'b1;
    end
    if (nxt_state == IOP_OFF) begin
      nxt_check = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff    <= IOP_OFF;
      check_ff    <= 1'b0;
      restored_ff <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      check_ff    <= nxt_check;
      restored_ff <= 1'b1;
    end
  end

  // hot intake pause with a continuous cool period before resuming
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hot_ff      <= 1'b0;
      cool_sec_ff <= 11'h000;
    end else if (intake_temp_i >= TEMP_HOT_C) begin
      hot_ff      <= 1'b1;
      cool_sec_ff <= 11'h000;
    end else if (hot_ff && tick_ff) begin
      if (cool_sec_ff == 11'(HOT_RESUME_S - 1)) begin
        hot_ff      <= 1'b0;
        cool_sec_ff <= 11'h000;
      end else begin
        cool_sec_ff <= cool_sec_ff + 11'h001;
      end
    end
  end

  // feedback is only judged after the supply has been up a full tick
  assign dis_evt = hv_en_ff & settled_ff & ~fb_db & ion_on;
  assign nxt_hv_en = ion_on && conn_db && !dis_wait_ff && !dis_evt
                     && (check_ff || (fan_run_i && !hot_ff));

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hv_en_ff   <= 1'b0;
      armed_ff   <= 1'b0;
      settled_ff <= 1'b0;
      off_arm_ff <= 1'b0;
      off_ok_ff  <= 1'b0;
    end else begin
      hv_en_ff   <= nxt_hv_en;
      // two ticks leave the debounced feedback time to follow the supply
      armed_ff   <= hv_en_ff && (armed_ff || tick_ff);
      settled_ff <= hv_en_ff && (settled_ff || (armed_ff && tick_ff));
      off_arm_ff <= !hv_en_ff && (off_arm_ff || tick_ff);
      off_ok_ff  <= !hv_en_ff && (off_ok_ff || (off_arm_ff && tick_ff));
    end
  end

  // supply stays off until the retry interval runs out
  always_ff @(posedge clk_i) begin
    if (rst_i || !ion_on) begin
      dis_wait_ff  <= 1'b0;
      retry_sec_ff <= 11'h000;
    end else if (dis_evt) begin
      dis_wait_ff  <= 1'b1;
      retry_sec_ff <= 11'h000;
    end else if (dis_wait_ff && tick_ff) begin
      if (retry_sec_ff == 11'(RETRY_S - 1)) begin
        dis_wait_ff  <= 1'b0;
        retry_sec_ff <= 11'h000;
      end else begin
        retry_sec_ff <= retry_sec_ff + 11'h001;
      end
    end
  end

  // consecutive discharge count and fault-free time
  always_ff @(posedge clk_i) begin
    if (rst_i || !ion_on) begin
      dis_cnt_ff <= 5'h00;
      ok_sec_ff  <= 10'h000;
    end else if (dis_evt) begin
      ok_sec_ff <= 10'h000;
      if (dis_cnt_ff < DIS_LIMIT) begin
        dis_cnt_ff <= dis_cnt_ff + 5'h01;
      end
    end else if (hv_en_ff && tick_ff) begin
      if (ok_sec_ff == 10'(OK_CLEAR_S - 1)) begin
        ok_sec_ff  <= 10'h000;
        dis_cnt_ff <= 5'h00;
      end else begin
        ok_sec_ff <= ok_sec_ff + 10'h001;
      end
    end
  end

  // a discharge in the same cycle as a clearing command still sets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dis_err_ff <= 1'b0;
    end else if (dis_evt
                 && (check_ff || dis_cnt_ff == DIS_LIMIT - 5'h01)) begin
      dis_err_ff <= 1'b1;
    end else if (err_clr) begin
      dis_err_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      brk_err_ff <= 1'b0;
    end else if (!ion_on && off_ok_ff && fb_db) begin
      brk_err_ff <= 1'b1;
    end else if (ion_on && !fb_db) begin
      brk_err_ff <= 1'b0;
    end
  end

  // auto fan alternation; a zero duration is treated as one second
  assign pat_lim = pat_cool_ff ? ctrl_ff[CTRL_CL_LSB +: 8]
                               : ctrl_ff[CTRL_UL_LSB +: 8];

  always_ff @(posedge clk_i) begin
    if (rst_i || !ion_on || !ctrl_ff[CTRL_PAT_EN]) begin
      pat_sec_ff  <= 8'h00;
      pat_cool_ff <= 1'b0;
    end else if (tick_ff) begin
      if (pat_sec_ff + 8'h01 >= pat_lim) begin
        pat_sec_ff  <= 8'h00;
        pat_cool_ff <= ~pat_cool_ff;
      end else begin
        pat_sec_ff <= pat_sec_ff + 8'h01;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_o <= '0;
    end else begin
      out_o.ion_on            <= ion_on;
      out_o.solo_limits       <= (state_ff == IOP_SOLO);
      out_o.hv_en             <= hv_en_ff;
      out_o.ion_led           <= ion_on;
      out_o.ion_blink         <= dis_err_ff || brk_err_ff
                                 || (!conn_db && (ion_on || aqm_active_i));
      out_o.tmr_blink         <= brk_err_ff;
      out_o.fan_step_cool_low <= pat_cool_ff;
      out_o.check             <= check_ff;
      out_o.beep_short        <= beep_s;
      out_o.beep_long         <= beep_l;
      out_o.resume_prev       <= resume_prev;
      out_o.saved_mode        <= state_ff;
    end
  end

  // wishbone classic slave, ack one cycle after the strobe
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == REG_CTRL) begin
      for (int i = 0; i < 4; i++) begin
        if (wb_sel_i[i]) begin
          ctrl_ff[8*i +: 8] <= wb_dat_i[8*i +: 8];
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          REG_CTRL: wb_dat_o <= ctrl_ff;
          REG_STATUS: begin
            wb_dat_o[ST_MODE_LSB +: 2] <= state_ff;
            wb_dat_o[ST_CHECK]         <= check_ff;
            wb_dat_o[ST_HV]            <= hv_en_ff;
            wb_dat_o[ST_DIS_ERR]       <= dis_err_ff;
            wb_dat_o[ST_BRK_ERR]       <= brk_err_ff;
            wb_dat_o[ST_CONN_OPEN]     <= ~conn_db;
            wb_dat_o[ST_HOT]           <= hot_ff;
            wb_dat_o[ST_CNT_LSB +: 5]  <= dis_cnt_ff;
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence s_start_req;
    restored_ff && release_w && !ion_on && !evt_i.off_tmr
      && !evt_i.pwr_stop && !evt_i.man_pwr && !evt_i.aqm_btn;
  endsequence

  a_start_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    s_start_req |=> state_ff == ($past(unit_run_i) ? IOP_COMB : IOP_SOLO))
    else $error("ionizer start picked the wrong mode");

  a_stop_events: assert property (@(posedge clk_i) disable iff (rst_i)
    restored_ff && (evt_i.off_tmr || evt_i.pwr_stop || evt_i.aqm_btn)
      |=> !ion_on ##1 !out_o.ion_on)
    else $error("stop event did not end ionizer operation");

  a_fan_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    !fan_run_i && !check_ff |=> !hv_en_ff ##1 !out_o.hv_en)
    else $error("supply stayed on with the fan stopped");

  a_hot_pause: assert property (@(posedge clk_i) disable iff (rst_i)
    intake_temp_i >= TEMP_HOT_C |=> hot_ff && cool_sec_ff == 11'h000)
    else $error("hot intake did not pause");

  a_dis_power: assert property (@(posedge clk_i) disable iff (rst_i)
    dis_evt |=> !hv_en_ff && dis_wait_ff)
    else $error("supply kept after abnormal discharge");

  a_err_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    restored_ff && (evt_i.pwr_stop || evt_i.off_tmr) && !dis_evt
      |=> !dis_err_ff)
    else $error("discharge error survived a stop");

  a_check_err: assert property (@(posedge clk_i) disable iff (rst_i)
    dis_evt && check_ff |=> dis_err_ff ##1 out_o.ion_blink)
    else $error("check mode did not show the error at once");

  a_led_start: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(ion_on) |=> out_o.ion_led)
    else $error("indicator not lit at ionizer start");

  a_long_beep: assert property (@(posedge clk_i) disable iff (rst_i)
    restored_ff && release_w && state_ff == IOP_SOLO
      && hold_sec_ff < 5'(CHECK_HOLD_S) && !evt_i.aqm_btn
      |=> out_o.beep_long)
    else $error("stand-alone stop without long beep");

  a_brk_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !ion_on && off_ok_ff && fb_db |=> brk_err_ff ##1 out_o.tmr_blink)
    else $error("breakdown not flagged");

endmodule : iop_ctrl

// ==== tb/iop_far_model.sv ====
// model of the purifier supply, its feedback line and main connector
// assumes hv_en_i comes straight from the controller outputs
`timescale 1ns/100ps
module iop_far_model (
  input  wire logic hv_en_i,
  input  wire logic short_i,
  input  wire logic brk_i,
  input  wire logic open_i,
  output logic      fb_raw_o,
  output logic      conn_raw_o
);
  // healthy supply returns high feedback only while energised;
  // a short pulls it low, a broken supply drives it high regardless
  assign fb_raw_o   = brk_i | (hv_en_i & ~short_i);
  assign conn_raw_o = ~open_i;
endmodule : iop_far_model

// ==== tb/tb_iop_ctrl.sv ====
// directed testbench for the ionizer control, wishbone and event driven
// assumes shortened time base: SEC_CYC 10 cycles, debounce 4 cycles
`timescale 1ns/100ps
module tb_iop_ctrl;
  import iop_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h0, temp = 8'h19;
  logic [31:0] wdat = 32'h0000_0000, rdat, wb_dat_o;
  logic        wb_ack_o, fb_raw, conn_raw;
  logic        unit_run = 1'b0, fan_run = 1'b1;
  logic        shrt = 1'b0, brk = 1'b0, opn = 1'b0;
  iop_evt_t    evt = '0;
  iop_state_t  nv = IOP_OFF;
  iop_out_t    out_o;
  int          n_errors = 0, tests_run = 0, n_bs = 0, n_bl = 0, n_rp = 0, b0;

  always #4 clk_i = ~clk_i;

  iop_ctrl #(.SEC_CYC(10), .DEB_CYC(4)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .evt_i(evt),
    .unit_run_i(unit_run), .aqm_active_i(1'b0), .fan_run_i(fan_run),
    .intake_temp_i(temp), .fb_raw_i(fb_raw), .conn_raw_i(conn_raw),
    .saved_mode_i(nv), .out_o(out_o));

  iop_far_model FAR (.hv_en_i(out_o.hv_en), .short_i(shrt), .brk_i(brk),
    .open_i(opn), .fb_raw_o(fb_raw), .conn_raw_o(conn_raw));

  // one-cycle pulses are counted here so no check can miss them
  always @(posedge clk_i) begin
    if (out_o.beep_short === 1'b1) n_bs++;
    if (out_o.beep_long === 1'b1) n_bl++;
    if (out_o.resume_prev === 1'b1) n_rp++;
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : settle

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("ack wait", 1'b1, n < 50);
  endtask : wb

  task automatic press(input int hold);
    @(posedge clk_i);
    evt.ion_btn <= 1'b1;
    repeat (hold) @(posedge clk_i);
    evt.ion_btn <= 1'b0;
    settle(14);
  endtask : press

  // event bits: 10 power stop, 08 monitor, 04 manual, 02 off, 01 on timer
  task automatic ev(input iop_evt_t e);
    @(posedge clk_i);
    evt <= e;
    @(posedge clk_i);
    evt <= '0;
    settle(4);
  endtask : ev

  task automatic endt(input string nm);
    $display("test %s done", nm);
  endtask : endt

  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report

  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    settle(20);
    chk("out idle", 13'h0, out_o);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", CTRL_RESET, rdat);
    wb(1'b1, 8'h10, 32'hffff_ffff);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0000_0000, rdat);
    wb(1'b1, REG_CTRL, 32'h0014_1401);
    wb(1'b0, REG_CTRL, 32'h0);
    chk("ctrl rw", 32'h0014_1401, rdat);
    endt("registers");
    b0 = n_bs;
    press(10);
    chk("ion_on", 1'b1, out_o.ion_on);
    chk("ion_led", 1'b1, out_o.ion_led);
    chk("solo", 1'b1, out_o.solo_limits);
    chk("saved", IOP_SOLO, out_o.saved_mode);
    chk("beep", 1, n_bs - b0);
    chk("hv on", 1'b1, out_o.hv_en);
    chk("upper low", 1'b0, out_o.fan_step_cool_low);
    @(posedge clk_i);
    fan_run <= 1'b0;
    settle(4);
    chk("fan pause", 1'b0, out_o.hv_en);
    @(posedge clk_i);
    fan_run <= 1'b1;
    settle(4);
    chk("fan resume", 1'b1, out_o.hv_en);
    settle(200);
    chk("cool low", 1'b1, out_o.fan_step_cool_low);
    endt("solo start");
    @(posedge clk_i);
    temp <= 8'h28;
    settle(4);
    chk("hot pause", 1'b0, out_o.hv_en);
    @(posedge clk_i);
    temp <= 8'h27;
    settle(17800);
    chk("hot hold", 1'b0, out_o.hv_en);
    settle(300);
    chk("hot resume", 1'b1, out_o.hv_en);
    endt("hot");
    @(posedge clk_i);
    shrt <= 1'b1;
    settle(30);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("hv cut", 1'b0, rdat[ST_HV]);
    chk("count 1", 5'h1, rdat[ST_CNT_LSB +: 5]);
    settle(17800);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("no retry", 5'h1, rdat[ST_CNT_LSB +: 5]);
    settle(300);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("retry", 5'h2, rdat[ST_CNT_LSB +: 5]);
    chk("no error", 1'b0, rdat[ST_DIS_ERR]);
    shrt <= 1'b0;
    b0 = n_bl;
    press(10);
    chk("stop", 1'b0, out_o.ion_on);
    chk("long beep", 1, n_bl - b0);
    wb(1'b0, REG_STATUS, 32'h0);
    chk("count clr", 5'h0, rdat[ST_CNT_LSB +: 5]);
    endt("discharge");
    press(10);
    press(200);
    chk("check", 1'b1, out_o.check);
    chk("check on", 1'b1, out_o.ion_on);
    @(posedge clk_i);
    shrt <= 1'b1;
    settle(40);
    chk("check blink", 1'b1, out_o.ion_blink);
    ev(6'h10);
    chk("pwr stop", 1'b0, out_o.ion_on);
    chk("err clr", 1'b0, out_o.ion_blink);
    endt("check mode");
    @(posedge clk_i);
    shrt <= 1'b0;
    unit_run <= 1'b1;
    b0 = n_bs;
    press(10);
    chk("comb", 1'b1, out_o.ion_on);
    chk("comb lim", 1'b0, out_o.solo_limits);
    chk("comb save", IOP_COMB, out_o.saved_mode);
    ev(6'h08);
    chk("aqm stop", 1'b0, out_o.ion_on);
    chk("beeps", 1, n_bs - b0);
    @(posedge clk_i);
    unit_run <= 1'b0;
    b0 = n_rp;
    ev(6'h01);
    chk("resume", 1, n_rp - b0);
    chk("no ion", 1'b0, out_o.ion_on);
    press(10);
    ev(6'h02);
    chk("off tmr", 1'b0, out_o.ion_on);
    endt("combined and timers");
    @(posedge clk_i);
    brk <= 1'b1;
    settle(24);
    chk("brk tmr", 1'b1, out_o.tmr_blink);
    chk("brk ion", 1'b1, out_o.ion_blink);
    @(posedge clk_i);
    brk <= 1'b0;
    shrt <= 1'b1;
    press(10);
    settle(20);
    chk("brk clr", 1'b0, out_o.tmr_blink);
    @(posedge clk_i);
    shrt <= 1'b0;
    opn <= 1'b1;
    settle(12);
    chk("conn blink", 1'b1, out_o.ion_blink);
    @(posedge clk_i);
    opn <= 1'b0;
    settle(12);
    chk("conn ok", 1'b0, out_o.ion_blink);
    endt("faults");
    @(posedge clk_i);
    nv <= IOP_SOLO;
    rst_i <= 1'b1;
    settle(2);
    @(posedge clk_i);
    rst_i <= 1'b0;
    settle(6);
    chk("restore", 1'b1, out_o.ion_on);
    endt("power return");
    final_report();
  end
endmodule : tb_iop_ctrl
